// >>> bench/cww_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module cww_mem_model
(
	// Clock
	input wire logic        mclk,
	// Memory side of the controller
	input wire logic        memStrobe,
	input wire logic        memProgram,
	input wire logic [23:0] memAddr,
	output logic     [15:0] memRdata
);
	logic [15:0] idleData = 16'h0f0f; // Pattern while not selected

	// Idle pattern flips each cycle so stale data never looks valid
	always_ff @(posedge mclk)
		idleData <= ~idleData;

	// Program space is marked by an xor so a wrong target shows
	assign memRdata = memStrobe ? (memAddr[15:0] ^ (memProgram ? 16'ha5a5 : 16'h0000)) : idleData;
endmodule : cww_mem_model

`default_nettype wire

// >>> bench/cww_memory_control_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cww_memory_control_chk
	import cww_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// Register port
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Core and memory side
	input wire logic        cpuReq,
	input wire logic [1:0]  cpuSpace,
	input wire logic        internalCodeFetch,
	input wire logic        internalRamHit,
	input wire logic        cpuReady,
	input wire logic        cpuDone,
	input wire logic        memStrobe,
	input wire logic        memProgram,
	input wire logic        memWrite,
	input wire logic [23:0] memAddr,
	input wire logic [7:0]  tableSegment
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic [7:0] progWait; // Shadow of the program wait register
	logic [3:0] busyCnt;  // Busy cycles since the take edge
	logic [3:0] expBusy;  // Busy cycles the take should cost
	logic       track;    // Only program and SFR costs are tracked
	logic       unmapped; // Address outside the four words
	assign unmapped = !(paddr inside {12'h02c, 12'h030, 12'h034, 12'h038});

	// Shadow follows completed writes only
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			progWait <= PROGRAM_WAIT_CONFIG_RESET;
		else if (psel && penable && pwrite && paddr == 12'h030)
			progWait <= pwdata[7:0];
	end

	// Count busy cycles; expectation latched at the take edge
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busyCnt <= 4'h0;
			expBusy <= 4'h0;
			track   <= 1'b0;
		end
		else if (cpuReady && cpuReq)
		begin
			busyCnt <= 4'h0;
			track   <= cpuSpace != SPACE_DATA;
			if (cpuSpace == SPACE_SFR)
				expBusy <= {1'b0, progWait[6:4]} + 4'h1;
			else if (internalCodeFetch && !progWait[2])
				expBusy <= 4'h1;
			else
				expBusy <= {2'b00, progWait[1:0]} + 4'h1;
		end
		else if (!cpuReady)
			busyCnt <= busyCnt + 4'h1;
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence ramTake;
		cpuReady && cpuReq && cpuSpace == SPACE_DATA && internalRamHit;
	endsequence

	chk_apb_ready: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	chk_addr_error: assert property (psel && !penable |=> pslverr == $past(unmapped))
		else $error("pslverr does not match address decode");
	chk_fixed_ones: assert property (psel && penable && !pwrite
		&& (paddr == 12'h030 || paddr == 12'h034) |-> (prdata & 32'hffff_ff88) == 32'h0000_0088)
		else $error("fixed one bits wrong");
	chk_wait_count: assert property (cpuDone && track |-> busyCnt == expBusy)
		else $error("program or SFR wait count wrong");
	chk_ram_first: assert property (ramTake |=> (!memStrobe && !cpuDone) ##1 cpuDone)
		else $error("internal RAM access not immediate");
	chk_strobe_hold: assert property (memStrobe |=> memStrobe || cpuDone)
		else $error("strobe dropped before completion");
	chk_strobe_busy: assert property (memStrobe |-> !cpuReady)
		else $error("ready while memory access held");
	chk_no_prog_write: assert property (memWrite |-> !memProgram)
		else $error("write strobe toward program memory");
	chk_done_pulse: assert property (cpuDone |-> cpuReady ##1 !cpuDone)
		else $error("done not a single cycle with ready");
	chk_segment_addr: assert property (memStrobe && memProgram |-> memAddr[23:16] == tableSegment)
		else $error("program access outside the table segment");
endmodule : cww_memory_control_chk

bind cww_memory_control cww_memory_control_chk u_chk (.*);

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
	import cww_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        cpuReq, cpuWrite, cpuWord, internalRamHit, internalCodeFetch;
	logic        cpuReady, cpuDone, memStrobe, memProgram, memWrite, memWord, err;
	logic [1:0]  cpuSpace;
	logic [15:0] cpuAddr, cpuWdata, cpuRdata, memWdata, memRdata;
	logic [7:0]  tableSegment;
	logic [23:0] memAddr;
	logic [15:0] ends [4] = '{WINDOW_END_00, WINDOW_END_01, WINDOW_END_10, WINDOW_END_11};
	int          num_errors, check_count;

	cww_memory_control dut (.*);
	cww_mem_model      mem (.*);

	// 250 MHz core clock
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic do_reset(input int n);
		reset_n <= 1'b0;
		repeat (n) @(posedge mclk);
		reset_n <= 1'b1;
	endtask : do_reset

	// One APB transfer; request held until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Core access: f is write, word, RAM hit, internal fetch; checks extra cycles
	task automatic acc(input string n, input logic [1:0] sp, input logic [3:0] f,
		input logic [15:0] a, input int xe, input logic [15:0] xd);
		int e;
		@(posedge mclk);
		cpuReq <= 1'b1;
		cpuSpace <= sp;
		{cpuWrite, cpuWord, internalRamHit, internalCodeFetch} <= f;
		cpuAddr <= a;
		do @(posedge mclk); while (cpuReady !== 1'b1);
		cpuReq <= 1'b0;
		e = -2;
		do
		begin
			@(posedge mclk);
			e++;
		end
		while (cpuDone !== 1'b1);
		check({n, " cycles"}, 32'(e), 32'(xe));
		// Data is meaningful only for memory reads
		if (!f[3] && !f[1] && sp != SPACE_SFR)
			check({n, " data"}, {16'h0000, cpuRdata}, {16'h0000, xd});
	endtask : acc

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, cpuReq, cpuWrite, cpuWord} = 6'h00;
		{internalRamHit, internalCodeFetch, reset_n} = 3'h0;
		{paddr, pwdata, cpuSpace, cpuAddr, cpuWdata} = '0;
		tableSegment = 8'h5a;
		num_errors = 0;
		check_count = 0;
		do_reset(20);
		// Reset values and decode error
		apb(1'b0, 12'h02c, 8'h00, rd, err); check("window reg", rd, 32'h0000_0030);
		apb(1'b0, 12'h030, 8'h00, rd, err); check("prog reg", rd, 32'h0000_008b);
		apb(1'b0, 12'h034, 8'h00, rd, err); check("data reg", rd, 32'h0000_00ff);
		apb(1'b0, 12'h03c, 8'h00, rd, err); check("unmapped", {31'h0, err}, 32'h0000_0001);
		acc("start zero", SPACE_DATA, 4'h0, 16'h3000, 9, 16'h3000);
		// Every program wait code
		for (int w = 0; w < 4; w++)
		begin
			apb(1'b1, 12'h030, w[7:0], rd, err);
			apb(1'b0, 12'h030, 8'h00, rd, err); check("prog wr", rd, 32'h0000_0088 | 32'(w));
			acc("prog ext", SPACE_PROGRAM, 4'h0, 16'h1234, w, 16'h1234 ^ 16'ha5a5);
		end
		acc("int off", SPACE_PROGRAM, 4'h1, 16'h0100, 0, 16'h0100 ^ 16'ha5a5);
		apb(1'b1, 12'h030, 8'h06, rd, err);
		acc("int on", SPACE_PROGRAM, 4'h1, 16'h0100, 2, 16'h0100 ^ 16'ha5a5);
		// Every SFR wait code
		for (int s = 0; s < 8; s++)
		begin
			apb(1'b1, 12'h030, {1'b0, s[2:0], 4'h0}, rd, err);
			acc("sfr", SPACE_SFR, 4'h0, 16'h0040, s, 16'h0000);
		end
		// Separate waits for the two data halves
		apb(1'b1, 12'h034, 8'h52, rd, err);
		apb(1'b0, 12'h034, 8'h00, rd, err); check("data wr", rd, 32'h0000_00da);
		acc("low byte", SPACE_DATA, 4'h0, 16'h7fff, 4, 16'h7fff);
		acc("high byte", SPACE_DATA, 4'h0, 16'h8000, 7, 16'h8000);
		acc("low word", SPACE_DATA, 4'h4, 16'h0200, 8, 16'h0200);
		acc("ext write", SPACE_DATA, 4'h8, 16'h0200, 4, 16'h0000);
		// Window 2000 to 7FFF, locked after first write
		apb(1'b1, 12'h02c, 8'h42, rd, err);
		apb(1'b1, 12'h02c, 8'h00, rd, err);
		apb(1'b0, 12'h02c, 8'h00, rd, err); check("window lock", rd, 32'h0000_0042);
		apb(1'b0, 12'h038, 8'h00, rd, err); check("status", rd, 32'h0000_0003);
		acc("win byte", SPACE_DATA, 4'h0, 16'h2000, 3, 16'h2000 ^ 16'ha5a5);
		acc("win word", SPACE_DATA, 4'h4, 16'h7ffe, 6, 16'h7ffe ^ 16'ha5a5);
		acc("below win", SPACE_DATA, 4'h0, 16'h1fff, 4, 16'h1fff);
		acc("win write", SPACE_DATA, 4'h8, 16'h3000, 0, 16'h0000);
		acc("win ram", SPACE_DATA, 4'h2, 16'h3000, 0, 16'h0000);
		// Each end code after a fresh reset
		for (int c = 0; c < 4; c++)
		begin
			do_reset(2);
			apb(1'b1, 12'h02c, {c[1:0], 6'h01}, rd, err);
			acc("win end", SPACE_DATA, 4'h0, ends[c], 3, ends[c] ^ 16'ha5a5);
			if (c < 3)
				acc("past end", SPACE_DATA, 4'h0, ends[c] + 16'h0001, 9, ends[c] + 16'h0001);
		end
		close_out();
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		close_out();
	end
endmodule : testbench

`default_nettype wire

// >>> rtl/cww_memory_control.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Window reads go to program memory, same address
// - Window reads add three byte, six word cycles
// - Window writes add no extra cycles
// - Config holds start low nibble, end top bits
// - Start digit zero disables the window
// - End select picks 3FFF, 7FFF, BFFF, FFFF
// - Internal RAM wins over the window
// - Window addresses never reach external data memory
// - Window config takes only first write after reset
// - Start versus end is never compared
// - Enable bit applies program waits to internal code
// - Lower and upper data halves have separate waits
// - Program waits zero to three, bits 1:0
// - SFR waits zero to seven, bits 6:4
// - Program wait bits 3, 7 fixed one
// - Reset loads program wait register with 8BH
// - Each wait cycle lasts one core clock
// - Data waits: bits 2:0 low, 6:4 high
// - Data waits add to two built-in cycles
module cww_memory_control
	import cww_pkg::*;
#(
	parameter int ADDR_WIDTH    = 16, // Data and program offset width
	parameter int SEGMENT_WIDTH = 8   // Table segment width
)
(
	// Clock and reset
	input  wire logic                            mclk,
	input  wire logic                            reset_n,
	// APB register port
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// Core access request
	input  wire logic                            cpuReq,
	input  wire logic [1:0]                      cpuSpace,
	input  wire logic                            cpuWrite,
	input  wire logic                            cpuWord,
	input  wire logic [ADDR_WIDTH-1:0]           cpuAddr,
	input  wire logic [15:0]                     cpuWdata,
	input  wire logic                            internalRamHit,
	input  wire logic                            internalCodeFetch,
	input  wire logic [SEGMENT_WIDTH-1:0]        tableSegment,
	output logic                                 cpuReady,
	output logic                                 cpuDone,
	output logic      [15:0]                     cpuRdata,
	// Memory side
	output logic                                 memStrobe,
	output logic                                 memProgram,
	output logic                                 memWrite,
	output logic                                 memWord,
	output logic      [SEGMENT_WIDTH+ADDR_WIDTH-1:0] memAddr,
	output logic      [15:0]                     memWdata,
	input  wire logic [15:0]                     memRdata
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The window decode works on a 16-bit offset only
	if (ADDR_WIDTH != 16)
	begin : gen_bad_addr
		$error("cww_memory_control: ADDR_WIDTH must be 16");
	end
	if (SEGMENT_WIDTH < 1 || SEGMENT_WIDTH > 16)
	begin : gen_bad_seg
		$error("cww_memory_control: SEGMENT_WIDTH must be 1 to 16");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// End address from the two-bit end select
	function automatic logic [15:0] windowEnd(input logic [1:0] sel);
		case (sel)
			2'b00:   windowEnd = WINDOW_END_00;
			2'b01:   windowEnd = WINDOW_END_01;
			2'b10:   windowEnd = WINDOW_END_10;
			default: windowEnd = WINDOW_END_11;
		endcase
	endfunction : windowEnd

	// Pick the data wait field for the half the address falls in
	function automatic logic [2:0] dataWaitFor(input logic [7:0] cfg, input logic [15:0] addr);
		if (addr[15])
			dataWaitFor = cfg[HIGH_DATA_WAIT_LSB +: 3];
		else
			dataWaitFor = cfg[LOW_DATA_WAIT_LSB +: 3];
	endfunction : dataWaitFor

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0]    codeWindowConfig;   // Window start and end
	logic          windowLocked;       // Set by the first write
	logic [7:0]    programWaitConfig;  // Only writable bits stored
	logic [7:0]    dataWaitConfig;     // Only writable bits stored
	logic          apbSetup;           // Setup phase of a transfer
	logic          apbAccess;          // Access phase of a transfer
	logic [9:0]    regIndex;           // Word index from the byte address
	logic          indexHit;           // Address names a register
	logic [7:0]    readValue;          // Value for the addressed register
	cww_state_type state;              // Access sequencer state
	logic [4:0]    waitLeft;           // Cycles still to hold the access
	logic          resultFromMemory;   // Read data is taken from memory
	logic [3:0]    windowStart;        // Start digit
	logic [15:0]   windowLast;         // Last address inside the window
	logic          windowActive;       // Start digit is not zero
	logic          inWindowRange;      // Address lies inside the window
	logic          windowRead;         // Data read served from program memory
	logic          windowWrite;        // Data write swallowed by the window

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign apbSetup  = psel && !penable;
	assign apbAccess = psel && penable;
	assign regIndex  = paddr[11:2];

	// Registers answer only on word-aligned addresses
	always_comb
	begin
		indexHit  = 1'b0;
		readValue = 8'h00;
		if (paddr[1:0] == 2'b00)
		begin
			case (regIndex)
				{2'b00, CODE_WINDOW_CONFIG_INDEX}:
				begin
					indexHit  = 1'b1;
					readValue = codeWindowConfig;
				end
				{2'b00, PROGRAM_WAIT_CONFIG_INDEX}:
				begin
					indexHit  = 1'b1;
					readValue = programWaitConfig | FIXED_ONE_BITS;
				end
				{2'b00, DATA_WAIT_CONFIG_INDEX}:
				begin
					indexHit  = 1'b1;
					readValue = dataWaitConfig | FIXED_ONE_BITS;
				end
				{2'b00, MEMORY_STATUS_INDEX}:
				begin
					indexHit  = 1'b1;
					readValue = {5'h00, (state == ST_BUSY), windowActive, windowLocked};
				end
				default:
				begin
					indexHit  = 1'b0;
					readValue = 8'h00;
				end
			endcase
		end
	end

	// Slave answers in the first access cycle: data is staged at setup
	assign pready = 1'b1;

	// Read data and error captured during the setup cycle
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (apbSetup)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, readValue};
			pslverr <= !indexHit;
		end
	end

	// ----------------------------------------------------------------
	// Code window register, write once
	// ----------------------------------------------------------------
	// A later write is dropped without error so old code keeps running
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			codeWindowConfig <= CODE_WINDOW_CONFIG_RESET;
			windowLocked     <= 1'b0;
		end
		else if (apbAccess && pwrite && indexHit &&
			regIndex == {2'b00, CODE_WINDOW_CONFIG_INDEX} && !windowLocked)
		begin
			codeWindowConfig <= pwdata[7:0];
			windowLocked     <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Wait registers
	// ----------------------------------------------------------------
	// Program wait register, reset to 8BH, fixed bits never stored
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			programWaitConfig <= PROGRAM_WAIT_CONFIG_RESET & ~FIXED_ONE_BITS;
		else if (apbAccess && pwrite && indexHit &&
			regIndex == {2'b00, PROGRAM_WAIT_CONFIG_INDEX})
			programWaitConfig <= pwdata[7:0] & ~FIXED_ONE_BITS;
	end

	// Data wait register, reset to all waits at maximum
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			dataWaitConfig <= DATA_WAIT_CONFIG_RESET & ~FIXED_ONE_BITS;
		else if (apbAccess && pwrite && indexHit &&
			regIndex == {2'b00, DATA_WAIT_CONFIG_INDEX})
			dataWaitConfig <= pwdata[7:0] & ~FIXED_ONE_BITS;
	end

	// ----------------------------------------------------------------
	// Window decode
	// ----------------------------------------------------------------
	assign windowStart  = codeWindowConfig[WINDOW_START_LSB +: 4];
	assign windowLast   = windowEnd(codeWindowConfig[WINDOW_END_LSB +: 2]);
	assign windowActive = (windowStart != 4'h0);
	// Start and end checked independently; an inverted pair just matches nothing
	assign inWindowRange = (cpuAddr[15:12] >= windowStart) &&
		(cpuAddr <= windowLast);
	// Internal RAM addresses are left alone even inside the range
	assign windowRead  = windowActive && inWindowRange && !internalRamHit &&
		(cpuSpace == SPACE_DATA) && !cpuWrite;
	assign windowWrite = windowActive && inWindowRange && !internalRamHit &&
		(cpuSpace == SPACE_DATA) && cpuWrite;

	// ----------------------------------------------------------------
	// Cycle budget for the incoming request
	// ----------------------------------------------------------------
	logic [1:0] programWait;   // Program wait count
	logic [2:0] sfrWait;       // SFR wait count
	logic [2:0] dataWait;      // Data wait for the addressed half
	logic [4:0] extraCycles;   // Cycles beyond the first
	logic       goesToMemory;  // Request drives the memory strobes
	logic       goesToProgram; // Request targets program memory

	assign programWait = programWaitConfig[PROGRAM_WAIT_LSB +: 2];
	assign sfrWait     = programWaitConfig[SFR_WAIT_LSB +: 3];
	assign dataWait    = dataWaitFor(dataWaitConfig, cpuAddr);

	// Each count is whole core clocks, so one wait is one cycle
	always_comb
	begin
		extraCycles   = 5'h00;
		goesToMemory  = 1'b0;
		goesToProgram = 1'b0;
		case (cpuSpace)
			SPACE_PROGRAM:
			begin
				goesToMemory  = 1'b1;
				goesToProgram = 1'b1;
				if (!internalCodeFetch)
					extraCycles = {3'b000, programWait};
				else if (programWaitConfig[INTERNAL_WAIT_BIT])
					extraCycles = {3'b000, programWait};
				else
					extraCycles = 5'h00;
			end
			SPACE_SFR:
			begin
				extraCycles = {2'b00, sfrWait};
			end
			SPACE_DATA:
			begin
				if (internalRamHit)
					extraCycles = 5'h00;
				else if (windowRead)
				begin
					goesToMemory  = 1'b1;
					goesToProgram = 1'b1;
					extraCycles = cpuWord ? WINDOW_WORD_EXTRA : WINDOW_BYTE_EXTRA;
				end
				else if (windowWrite)
					extraCycles = 5'h00;
				else
				begin
					goesToMemory = 1'b1;
					// Word access is two byte accesses
					if (cpuWord)
						extraCycles = 5'((EXT_DATA_BASE + {2'b00, dataWait}) << 1);
					else
						extraCycles = EXT_DATA_BASE + {2'b00, dataWait};
				end
			end
			default:
			begin
				extraCycles = 5'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	// Requests are taken only while idle
	assign cpuReady = (state == ST_IDLE);

	// State and wait counter
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state    <= ST_IDLE;
			waitLeft <= 5'h00;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (cpuReq)
					begin
						state    <= ST_BUSY;
						waitLeft <= extraCycles;
					end
				end
				ST_BUSY:
				begin
					if (waitLeft == 5'h00)
						state <= ST_IDLE;
					else
						waitLeft <= waitLeft - 5'h01;
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Memory strobes and address, latched once and held until done
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			memStrobe        <= 1'b0;
			memProgram       <= 1'b0;
			memWrite         <= 1'b0;
			memWord          <= 1'b0;
			memAddr          <= '0;
			memWdata         <= 16'h0000;
			resultFromMemory <= 1'b0;
		end
		else if (state == ST_IDLE && cpuReq)
		begin
			memStrobe        <= goesToMemory;
			memProgram       <= goesToProgram;
			memWrite         <= cpuWrite && goesToMemory;
			memWord          <= cpuWord;
			// Every request carries the table segment in the upper address bits
			memAddr          <= {tableSegment, cpuAddr};
			memWdata         <= cpuWdata;
			resultFromMemory <= goesToMemory && !cpuWrite;
		end
		else if (state == ST_BUSY && waitLeft == 5'h00)
		begin
			memStrobe <= 1'b0;
			memWrite  <= 1'b0;
		end
	end

	// Completion pulse and read data
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cpuDone  <= 1'b0;
			cpuRdata <= 16'h0000;
		end
		else
		begin
			cpuDone <= (state == ST_BUSY) && (waitLeft == 5'h00);
			if (state == ST_BUSY && waitLeft == 5'h00 && resultFromMemory)
				cpuRdata <= memRdata;
		end
	end

endmodule : cww_memory_control

`default_nettype wire

// >>> rtl/cww_pkg.sv
package cww_pkg;

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_WINDOW_CONFIG_INDEX  = 8'h0b; // Window start and end
	localparam logic [7:0] PROGRAM_WAIT_CONFIG_INDEX = 8'h0c; // Program and SFR waits
	localparam logic [7:0] DATA_WAIT_CONFIG_INDEX    = 8'h0d; // Low and high data waits
	localparam logic [7:0] MEMORY_STATUS_INDEX       = 8'h0e; // Lock and busy flags

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_WINDOW_CONFIG_RESET  = 8'h30;
	localparam logic [7:0] PROGRAM_WAIT_CONFIG_RESET = 8'h8b;
	localparam logic [7:0] DATA_WAIT_CONFIG_RESET    = 8'hff;
	localparam logic [7:0] FIXED_ONE_BITS            = 8'h88; // Bits 7 and 3 read as one

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int WINDOW_START_LSB    = 0; // Start digit, bits 3:0
	localparam int WINDOW_END_LSB      = 6; // End select, bits 7:6
	localparam int PROGRAM_WAIT_LSB    = 0; // Program waits, bits 1:0
	localparam int INTERNAL_WAIT_BIT   = 2; // Internal code wait enable
	localparam int SFR_WAIT_LSB        = 4; // SFR waits, bits 6:4
	localparam int LOW_DATA_WAIT_LSB   = 0; // Waits below the half point
	localparam int HIGH_DATA_WAIT_LSB  = 4; // Waits above the half point

	// ----------------------------------------------------------------
	// Window end addresses by end select code
	// ----------------------------------------------------------------
	localparam logic [15:0] WINDOW_END_00 = 16'h3fff;
	localparam logic [15:0] WINDOW_END_01 = 16'h7fff;
	localparam logic [15:0] WINDOW_END_10 = 16'hbfff;
	localparam logic [15:0] WINDOW_END_11 = 16'hffff;

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam logic [4:0] WINDOW_BYTE_EXTRA = 5'h03; // Extra cycles, byte window read
	localparam logic [4:0] WINDOW_WORD_EXTRA = 5'h06; // Extra cycles, word window read
	localparam logic [4:0] EXT_DATA_BASE     = 5'h02; // Built-in cycles per external byte

	// ----------------------------------------------------------------
	// Access spaces requested by the core
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SPACE_PROGRAM = 2'b00,
		SPACE_DATA    = 2'b01,
		SPACE_SFR     = 2'b10
	} cww_space_type;

	// Sequencer states
	typedef enum logic [0:0]
	{
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} cww_state_type;

endpackage : cww_pkg
